// >>> pmi_port.sv
`timescale 1ns/100ps
`default_nettype none
module pmi_port
  import pmi_pkg::*;
#(
  parameter int unsigned HALF_FAST = pmi_pkg::MII_HALF_100,
  parameter int unsigned HALF_SLOW = pmi_pkg::MII_HALF_10,
  parameter int unsigned DIBIT_HOLD = pmi_pkg::DIBIT_HOLD_10
) (
  input wire logic i_clock,                            // System clock
  input wire logic i_nrst,                             // Async reset, active low
  input wire logic i_mode_strap,                       // Mode strap pin, high picks RMII
  input wire logic i_if_disable,                       // Interface disable bit
  input wire logic i_speed_100,                        // Resolved speed, high for 100 Mbps
  input wire logic i_full_duplex,                      // Resolved duplex
  input wire logic i_ref_clk,                          // RMII reference clock pin
  input wire logic [pmi_pkg::NIB_W-1:0] i_mac_txd,     // Transmit data pins
  input wire logic i_mac_txen,                         // Transmit strobe pin
  input wire logic i_mac_txer,                         // Transmit error pin
  input wire logic i_line_carrier,                     // Carrier from line receiver
  input wire logic i_line_rx_valid,                    // Received nibble valid
  input wire logic [pmi_pkg::NIB_W-1:0] i_line_rx_nib, // Received nibble
  input wire logic i_line_rx_err,                      // Received nibble decode error
  input wire logic i_line_rx_sfd,                      // Nibble ends start delimiter
  output logic o_line_rx_ready,                        // Buffer can take a nibble
  output logic o_line_tx_valid,                        // Transmit nibble pulse
  output logic [pmi_pkg::NIB_W-1:0] o_line_tx_nib,     // Transmit nibble
  output logic o_line_tx_err,                          // Transmit error with nibble
  output logic o_line_tx_en,                           // Transmit active level
  output logic o_mac_txclk,                            // Transmit clock to MAC
  output logic o_mac_rxclk,                            // Receive clock to MAC
  output logic [pmi_pkg::NIB_W-1:0] o_mac_rxd,         // Receive data pins
  output logic o_mac_rxdv,                             // Receive strobe
  output logic o_mac_rxer,                             // Receive error
  output logic o_mac_crs,                              // Carrier sense
  output logic o_mac_col,                              // Collision, or CRS_DV in RMII
  output logic o_rmii_mode                             // Caught mode, high for RMII
);
  import pmi_pkg::*;

  localparam logic [7:0] HALF_F = 8'(HALF_FAST - 1);
  localparam logic [7:0] HALF_S = 8'(HALF_SLOW - 1);
  localparam logic [3:0] HOLD_LAST = 4'(DIBIT_HOLD - 1);

  // Synchronised pins
  logic [7:0] pins_s;
  wire ref_s = pins_s[0];
  wire [NIB_W-1:0] txd_s = pins_s[4:1];
  wire txen_s = pins_s[5];
  wire txer_s = pins_s[6];
  wire strap_s = pins_s[7];

  pmi_sync #(.W(8)) u_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_mode_strap, i_mac_txer, i_mac_txen, i_mac_txd, i_ref_clk}),
    .o_sync(pins_s)
  );

  // Elasticity buffer between line and MAC
  pmi_buf_if #(.W(ENT_W)) rxb ();

  pmi_rx_buf #(.W(ENT_W), .DEPTH(BUF_DEPTH)) u_buf (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .bus(rxb)
  );

  // Fill side of the buffer
  assign rxb.wr_valid = i_line_rx_valid;
  assign rxb.wr_data = {i_line_rx_sfd, i_line_rx_err, i_line_rx_nib};
  assign o_line_rx_ready = rxb.wr_ready;

  // Mode strap capture
  pmi_mode_t mode_q;
  pmi_mode_t mode_d;
  logic [1:0] wait_q;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PMI_ST_WAIT: begin
        if (wait_q == STRAP_WAIT) begin
          mode_d = strap_s ? PMI_ST_RMII : PMI_ST_MII;
        end
      end
      PMI_ST_MII: mode_d = PMI_ST_MII;
      PMI_ST_RMII: mode_d = PMI_ST_RMII;
      default: mode_d = PMI_ST_WAIT;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= PMI_ST_WAIT;
      wait_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      wait_q <= (wait_q == STRAP_WAIT) ? wait_q : wait_q + 2'h1;
    end
  end

  wire is_mii = (mode_q == PMI_ST_MII);
  wire is_rmii = (mode_q == PMI_ST_RMII);
  wire live = ~i_if_disable;

  // Reference clock edge detection and di-bit slots
  logic ref_q;
  logic [3:0] hold_q;
  wire ref_rise = ref_s & ~ref_q;
  wire hold_end = i_speed_100 | (hold_q == HOLD_LAST);
  wire rslot = is_rmii & ref_rise & hold_end;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_q <= 1'b0;
      hold_q <= 4'h0;
    end else begin
      ref_q <= ref_s;
      if (ref_rise) begin
        hold_q <= hold_end ? 4'h0 : hold_q + 4'h1;
      end
    end
  end

  // Generated MII clock, shared by transmit and receive
  logic [7:0] mcnt_q;
  logic mclk_q;
  wire [7:0] half_last = i_speed_100 ? HALF_F : HALF_S;
  wire mwrap = (mcnt_q >= half_last); // Also recovers after a slow-to-fast switch
  wire mii_fall = is_mii & mwrap & mclk_q;
  wire mclk_d = mwrap ? ~mclk_q : mclk_q;
  wire tx_samp = is_mii & mclk_q & (mcnt_q == TX_SAMPLE_AT);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mcnt_q <= 8'h00;
      mclk_q <= 1'b0;
    end else begin
      mcnt_q <= mwrap ? 8'h00 : mcnt_q + 8'h01;
      mclk_q <= mclk_d;
    end
  end

  // Drain side of the buffer
  logic rphase_q;
  wire [NIB_W-1:0] ent_nib = rxb.rd_data[ENT_NIB_LSB +: NIB_W];
  wire ent_err = rxb.rd_data[ENT_ERR_POS];
  wire ent_sfd = rxb.rd_data[ENT_SFD_POS];
  wire rslot_first = rslot & ~rphase_q;
  wire rslot_second = rslot & rphase_q;
  assign rxb.rd_ready = mii_fall | rslot_first;
  wire pop = rxb.rd_ready & rxb.rd_valid;

  // RMII nibble held for its second di-bit
  logic [NIB_W-1:0] rnib_q;
  logic rhave_q;
  logic rerr_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rphase_q <= 1'b0;
      rnib_q <= RXD_RST;
      rhave_q <= 1'b0;
      rerr_q <= 1'b0;
    end else if (rslot_first) begin
      rphase_q <= 1'b1;
      rnib_q <= pop ? ent_nib : RXD_RST;
      rhave_q <= pop;
      rerr_q <= pop & ent_err;
    end else if (rslot_second) begin
      rphase_q <= 1'b0;
    end
  end

  // Carrier sense / data valid for RMII
  logic crs_dv_q;
  wire crs_dv_first = i_line_carrier;
  wire crs_dv_second = i_line_carrier | crs_dv_q | rhave_q;
  wire crs_dv_hold = i_line_carrier | crs_dv_q;
  wire crs_dv_d = rslot_first ? crs_dv_first : (rslot_second ? crs_dv_second : crs_dv_hold);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      crs_dv_q <= 1'b0;
    end else begin
      crs_dv_q <= is_rmii & crs_dv_d;
    end
  end

  // Receive data selection per mode
  logic [NIB_W-1:0] rxd_q;
  logic rxdv_q;
  logic rxer_q;
  wire [DIBIT_W-1:0] dibit_first = pop ? ent_nib[1:0] : 2'h0;
  wire [DIBIT_W-1:0] dibit_second = rnib_q[3:2];
  wire [NIB_W-1:0] rxd_mii = pop ? ent_nib : RXD_RST;
  wire rxdv_mii = pop & (ent_sfd | rxdv_q);
  wire [NIB_W-1:0] rxd_rmii = {2'h0, rslot_first ? dibit_first : dibit_second};
  wire rxer_rmii = rslot_first ? (pop & ent_err) : rerr_q;
  wire rx_upd = mii_fall | rslot;
  wire [NIB_W-1:0] rxd_d = is_mii ? rxd_mii : rxd_rmii;
  wire rxdv_d = is_mii & rxdv_mii;
  wire rxer_d = is_mii ? (pop & ent_err) : rxer_rmii;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rxd_q <= RXD_RST;
      rxdv_q <= 1'b0;
      rxer_q <= 1'b0;
    end else if (!live) begin
      rxd_q <= RXD_RST;
      rxdv_q <= 1'b0;
      rxer_q <= 1'b0;
    end else if (rx_upd) begin
      rxd_q <= rxd_d;
      rxdv_q <= rxdv_d;
      rxer_q <= rxer_d;
    end
  end

  // Carrier sense and collision in MII, CRS_DV on the collision pin in RMII
  wire half_dup = ~i_full_duplex;
  wire crs_mii = i_line_carrier | (half_dup & txen_s);
  wire col_mii = half_dup & i_line_carrier & txen_s;
  wire crs_pin_d = live & is_mii & crs_mii;
  wire col_pin_d = live & (is_mii ? col_mii : (is_rmii & crs_dv_d));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mac_crs <= 1'b0;
      o_mac_col <= 1'b0;
      o_mac_txclk <= 1'b0;
      o_mac_rxclk <= 1'b0;
      o_rmii_mode <= 1'b0;
    end else begin
      o_mac_crs <= crs_pin_d;
      o_mac_col <= col_pin_d;
      o_mac_txclk <= live & is_mii & mclk_d;
      o_mac_rxclk <= live & is_mii & mclk_d;
      o_rmii_mode <= is_rmii;
    end
  end

  // Receive outputs straight from their flops
  assign o_mac_rxd = rxd_q;
  assign o_mac_rxdv = rxdv_q;
  assign o_mac_rxer = rxer_q;

  // Transmit path: MII nibble per clock, RMII di-bit pairs
  logic tphase_q;
  logic [DIBIT_W-1:0] tlow_q;
  wire rmii_tx_done = rslot & txen_s & tphase_q;
  wire [NIB_W-1:0] rmii_nib = {txd_s[1:0], tlow_q};

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tphase_q <= 1'b0;
      tlow_q <= 2'h0;
    end else if (rslot) begin
      tphase_q <= txen_s & ~tphase_q;
      tlow_q <= txd_s[1:0];
    end
  end

  // Line-side transmit outputs
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_line_tx_valid <= 1'b0;
      o_line_tx_nib <= RXD_RST;
      o_line_tx_err <= 1'b0;
      o_line_tx_en <= 1'b0;
    end else if (tx_samp) begin
      o_line_tx_valid <= txen_s;
      o_line_tx_nib <= txd_s;
      o_line_tx_err <= txen_s & txer_s;
      o_line_tx_en <= txen_s;
    end else if (rslot) begin
      o_line_tx_valid <= rmii_tx_done;
      o_line_tx_nib <= rmii_tx_done ? rmii_nib : o_line_tx_nib;
      o_line_tx_err <= 1'b0;
      o_line_tx_en <= txen_s;
    end else begin
      o_line_tx_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pmi_pkg.sv
`default_nettype none
package pmi_pkg;
  // Data widths
  localparam int unsigned NIB_W = 4;
  localparam int unsigned DIBIT_W = 2;
  // Receive buffer entry layout: {sfd, err, nibble}
  localparam int unsigned ENT_NIB_LSB = 0;
  localparam int unsigned ENT_ERR_POS = 4;
  localparam int unsigned ENT_SFD_POS = 5;
  localparam int unsigned ENT_W = 6;
  localparam int unsigned BUF_DEPTH = 2;
  // System clock rate
  localparam int unsigned CLK_HZ = 10_000_000;
  // Reference clock edges per di-bit at 10 Mbps
  localparam int unsigned DIBIT_HOLD_10 = 10;
  // Generated MII clock half periods in system clocks
  localparam int unsigned MII_HALF_100 = 4;
  localparam int unsigned MII_HALF_10 = 40;
  // Synchroniser latency and transmit sample point after a generated rising edge
  localparam int unsigned SYNC_LAT = 2;
  localparam logic [7:0] TX_SAMPLE_AT = 8'(SYNC_LAT);
  // Cycles after reset release before the mode strap is caught
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Reset values
  localparam logic [NIB_W-1:0] RXD_RST = 4'h0;
  localparam logic [ENT_W-1:0] ENT_RST = 6'h00;
  // Mode of the MAC port, one-hot
  typedef enum logic [2:0] {
    PMI_ST_WAIT = 3'b001,
    PMI_ST_MII = 3'b010,
    PMI_ST_RMII = 3'b100
  } pmi_mode_t;
endpackage
`default_nettype wire

// >>> pmi_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pmi_buf_if #(parameter int unsigned W = 6);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  // The buffer itself
  modport store (input wr_valid, input wr_data, input rd_ready,
                 output wr_ready, output rd_valid, output rd_data);
  // The port logic that fills and drains it
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface
`default_nettype wire

// >>> pmi_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pmi_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clock,           // System clock
  input wire logic i_nrst,            // Async reset, active low
  input wire logic [W-1:0] i_async,   // Signals from outside the domain
  output logic [W-1:0] o_sync         // Synchronised copies
);
  logic [W-1:0] meta_q;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> pmi_rx_buf.sv
`timescale 1ns/100ps
`default_nettype none
module pmi_rx_buf #(
  parameter int unsigned W = 6,
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clock,  // System clock
  input wire logic i_nrst,   // Async reset, active low
  pmi_buf_if.store bus       // Fill and drain sides
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_MAX = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [PW:0] cnt_q;
  logic full_q;
  logic empty_q;
  wire push = bus.wr_valid & ~full_q;
  wire pop = bus.rd_ready & ~empty_q;
  wire [PW:0] cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

  // Handshake flags straight from flops
  assign bus.wr_ready = ~full_q;
  assign bus.rd_valid = ~empty_q;
  assign bus.rd_data = mem_q[rptr_q];

  // Storage
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wptr_q] <= bus.wr_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PTR_LAST) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == PTR_LAST) ? '0 : rptr_q + 1'b1;
      end
      cnt_q <= cnt_d;
      full_q <= (cnt_d == CNT_MAX);
      empty_q <= (cnt_d == '0);
    end
  end
endmodule
`default_nettype wire

// >>> pmi_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pmi_port_asserts (
  input wire logic i_clock, // System clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_if_disable, // Interface disable
  input wire logic i_full_duplex, // Duplex
  input wire logic i_line_carrier, // Line carrier
  input wire logic o_line_tx_valid, // Transmit nibble pulse
  input wire logic o_mac_txclk, // MII transmit clock
  input wire logic o_mac_rxclk, // MII receive clock
  input wire logic [pmi_pkg::NIB_W-1:0] o_mac_rxd, // Receive data
  input wire logic o_mac_rxdv, // Receive strobe
  input wire logic o_mac_rxer, // Receive error
  input wire logic o_mac_crs, // Carrier sense
  input wire logic o_mac_col, // Collision or CRS_DV
  input wire logic o_rmii_mode // Caught mode
);
  import pmi_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Port rules seen at the pins
  a_disable_low: assert property (i_if_disable |=> o_mac_rxd == '0 && !o_mac_rxdv && !o_mac_rxer
    && !o_mac_crs && !o_mac_col && !o_mac_txclk && !o_mac_rxclk) else $error("MAC outputs active while disabled");
  a_rmii_quiet: assert property (o_rmii_mode |-> !o_mac_rxdv && !o_mac_crs && !o_mac_txclk && !o_mac_rxclk)
    else $error("MII-only outputs active in RMII");
  a_rmii_upper: assert property (o_rmii_mode |-> o_mac_rxd[3:2] == 2'h0)
    else $error("Upper receive lines not zero in RMII");
  a_crsdv_carrier: assert property (o_rmii_mode && !i_if_disable && i_line_carrier |=> o_mac_col)
    else $error("CRS_DV low during carrier");
  a_full_no_col: assert property (!o_rmii_mode && i_full_duplex |=> !o_mac_col)
    else $error("Collision in full duplex");
  a_half_crs: assert property (!o_rmii_mode && !i_if_disable && i_line_carrier |=> o_mac_crs)
    else $error("Carrier sense low during carrier");
  a_txvalid_pulse: assert property (o_line_tx_valid |=> !o_line_tx_valid)
    else $error("Transmit nibble pulse longer than one cycle");
  a_rxd_stands: assert property ($fell(o_mac_rxclk) |=> $stable(o_mac_rxd) [*7])
    else $error("Receive data changed within a clock period");
  // Main scenarios reached
  c_tx: cover property (o_line_tx_valid);
  c_rxdv: cover property (o_mac_rxdv);
  c_crsdv: cover property (o_rmii_mode && o_mac_col);
endmodule
bind pmi_port pmi_port_asserts pmi_port_asserts_inst (.i_clock, .i_nrst, .i_if_disable, .i_full_duplex,
  .i_line_carrier, .o_line_tx_valid, .o_mac_txclk, .o_mac_rxclk, .o_mac_rxd, .o_mac_rxdv, .o_mac_rxer,
  .o_mac_crs, .o_mac_col, .o_rmii_mode);
`default_nettype wire

// >>> pmi_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmi_mac_model (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_txclk, // MII transmit clock
  input wire logic i_rxclk, // MII receive clock
  input wire logic [pmi_pkg::NIB_W-1:0] i_rxd, // Receive data
  input wire logic i_rxdv, // Receive strobe
  input wire logic i_rxer, // Receive error
  input wire logic i_rmii, // High for RMII
  input wire logic i_slow, // High for 10 Mbps
  output logic [pmi_pkg::NIB_W-1:0] o_txd, // Transmit data
  output logic o_txen, // Transmit strobe
  output logic o_txer // Transmit error
);
  import pmi_pkg::*;
  logic [4:0] rx_q[$];
  initial begin
    o_txd = 4'h0;
    o_txen = 1'b0;
    o_txer = 1'b0;
  end
  // Capture nibbles on the receive clock rise while valid
  always @(posedge i_rxclk) if (i_rxdv === 1'b1) rx_q.push_back({i_rxer, i_rxd});
  // One transfer, changed just after the clock edge of the mode
  task beat(input logic [3:0] d, input logic en, input logic er);
    if (i_rmii) repeat (i_slow ? DIBIT_HOLD_10 : 1) @(posedge i_ref_clk);
    else @(posedge i_txclk);
    o_txd = d;
    o_txen = en;
    o_txer = er & en;
  endtask
  // Whole nibble, low di-bit first in RMII
  task send(input logic [3:0] n, input logic er);
    if (i_rmii) begin
      beat({2'h0, n[1:0]}, 1'b1, 1'b0);
      beat({2'h0, n[3:2]}, 1'b1, 1'b0);
    end else beat(n, 1'b1, er);
  endtask
  // End of frame: strobe low, data no longer meaningful
  task stop();
    beat(i_rmii ? {2'h0, ~o_txd[1:0]} : ~o_txd, 1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// >>> pmi_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pmi_port_tb;
  import pmi_pkg::*;
  logic i_clock, i_nrst, i_mode_strap, i_if_disable, i_speed_100, i_full_duplex, i_ref_clk;
  logic i_mac_txen, i_mac_txer, i_line_carrier, i_line_rx_valid, i_line_rx_err, i_line_rx_sfd;
  logic [NIB_W-1:0] i_mac_txd, i_line_rx_nib, o_line_tx_nib, o_mac_rxd;
  logic o_line_rx_ready, o_line_tx_valid, o_line_tx_err, o_line_tx_en, o_mac_txclk, o_mac_rxclk;
  logic o_mac_rxdv, o_mac_rxer, o_mac_crs, o_mac_col, o_rmii_mode, rmon, saw_full, saw_err;
  logic [4:0] tx_q[$];
  logic [1:0] rm_q[$];
  int n_mismatch = 0;
  int compares = 0;
  pmi_port pmi_port_inst (.i_clock, .i_nrst, .i_mode_strap, .i_if_disable, .i_speed_100, .i_full_duplex,
    .i_ref_clk, .i_mac_txd, .i_mac_txen, .i_mac_txer, .i_line_carrier, .i_line_rx_valid, .i_line_rx_nib,
    .i_line_rx_err, .i_line_rx_sfd, .o_line_rx_ready, .o_line_tx_valid, .o_line_tx_nib, .o_line_tx_err,
    .o_line_tx_en, .o_mac_txclk, .o_mac_rxclk, .o_mac_rxd, .o_mac_rxdv, .o_mac_rxer, .o_mac_crs, .o_mac_col,
    .o_rmii_mode);
  pmi_mac_model mac_inst (.i_ref_clk(i_ref_clk), .i_txclk(o_mac_txclk), .i_rxclk(o_mac_rxclk), .i_rxd(o_mac_rxd),
    .i_rxdv(o_mac_rxdv), .i_rxer(o_mac_rxer), .i_rmii(o_rmii_mode), .i_slow(!i_speed_100), .o_txd(i_mac_txd),
    .o_txen(i_mac_txen), .o_txer(i_mac_txer));
  // Clocks: system and an unrelated reference
  always #50 i_clock = ~i_clock;
  initial begin
    i_ref_clk = 1'b0;
    #23;
    forever #400 i_ref_clk = ~i_ref_clk;
  end
  // Monitors of line transmit, buffer refusal and RMII receive
  always @(negedge i_clock) begin
    if (o_line_tx_valid === 1'b1) tx_q.push_back({o_line_tx_err, o_line_tx_nib});
    if (i_line_rx_valid && o_line_rx_ready === 1'b0) saw_full = 1'b1;
  end
  always @(posedge i_ref_clk) if (rmon && o_mac_col === 1'b1) begin
    rm_q.push_back(o_mac_rxd[1:0]);
    if (o_mac_rxer === 1'b1) saw_err = 1'b1;
  end
  task stop_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Offer one entry {sfd, err, nibble}; valid stays up for the next
  task push(input logic [5:0] e);
    int k;
    {i_line_rx_sfd, i_line_rx_err, i_line_rx_nib} = e;
    i_line_rx_valid = 1'b1;
    for (k = 0; k < 1000 && o_line_rx_ready !== 1'b1; k++) @(negedge i_clock);
    @(negedge i_clock);
  endtask
  task t_reset(input logic s);
    i_nrst = 1'b0;
    i_mode_strap = s;
    repeat (5) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_clock);
    `CHK(o_rmii_mode, s);
  endtask
  task t_mii_tx();
    tx_q.delete();
    mac_inst.send(4'h3, 1'b0);
    mac_inst.send(4'hC, 1'b1);
    mac_inst.send(4'h0, 1'b0);
    mac_inst.stop();
    repeat (20) @(negedge i_clock);
    `CHK(tx_q.size(), 3);
    `CHK({tx_q[0], tx_q[1], tx_q[2]}, 15'h0F80);
  endtask
  task t_mii_rx(input logic fast);
    i_speed_100 = fast;
    i_full_duplex = 1'b1;
    i_line_carrier = 1'b1;
    saw_full = 1'b0;
    mac_inst.rx_q.delete();
    push(6'h05);
    push(6'h05);
    push(6'h2D);
    push(6'h1A);
    push(6'h03);
    i_line_rx_valid = 1'b0;
    repeat (fast ? 60 : 500) @(negedge i_clock);
    i_line_carrier = 1'b0;
    `CHK(mac_inst.rx_q.size(), 3);
    `CHK({mac_inst.rx_q[0], mac_inst.rx_q[1], mac_inst.rx_q[2]}, 15'h3743);
    if (!fast) `CHK(saw_full, 1'b1);
  endtask
  task t_col();
    i_full_duplex = 1'b0;
    i_line_carrier = 1'b1;
    mac_inst.send(4'h1, 1'b0);
    repeat (6) @(negedge i_clock);
    `CHK(o_mac_col, 1'b1);
    `CHK(o_line_tx_en, 1'b1);
    i_full_duplex = 1'b1;
    repeat (2) @(negedge i_clock);
    `CHK(o_mac_col, 1'b0);
    mac_inst.stop();
    @(negedge i_clock);
    i_line_carrier = 1'b0;
    i_full_duplex = 1'b0;
    repeat (4) @(negedge i_clock);
  endtask
  task t_rmii_tx(input logic fast);
    i_speed_100 = fast;
    tx_q.delete();
    mac_inst.send(4'h9, 1'b0);
    mac_inst.send(4'h6, 1'b0);
    mac_inst.stop();
    repeat (fast ? 20 : 200) @(negedge i_clock);
    `CHK(tx_q.size(), 2);
    `CHK({tx_q[0], tx_q[1]}, 10'h126);
  endtask
  task t_rmii_rx();
    int rises;
    logic prev;
    i_speed_100 = 1'b1;
    i_line_carrier = 1'b1;
    rm_q.delete();
    saw_err = 1'b0;
    rmon = 1'b1;
    push(6'h0D);
    push(6'h13);
    i_line_rx_valid = 1'b0;
    repeat (80) @(negedge i_clock);
    rmon = 1'b0;
    i_line_carrier = 1'b0;
    while (rm_q.size() > 0 && rm_q[0] === 2'h0) void'(rm_q.pop_front());
    `CHK({rm_q[0], rm_q[1], rm_q[2], rm_q[3]}, 8'h7C);
    `CHK(saw_err, 1'b1);
    repeat (24) @(negedge i_clock);
    `CHK(o_mac_col, 1'b0);
    // Carrier drops with nibbles still buffered: CRS_DV toggles per nibble
    i_line_carrier = 1'b1;
    push(6'h05);
    push(6'h05);
    i_line_rx_valid = 1'b0;
    i_line_carrier = 1'b0;
    rises = 0;
    prev = o_mac_col;
    repeat (64) begin
      @(negedge i_clock);
      if (o_mac_col === 1'b1 && prev === 1'b0) rises++;
      prev = o_mac_col;
    end
    `CHK(rises != 0, 1'b1);
    `CHK(o_mac_col, 1'b0);
  endtask
  task t_disable();
    i_line_carrier = 1'b1;
    repeat (4) @(negedge i_clock);
    `CHK(o_mac_col, 1'b1);
    i_if_disable = 1'b1;
    repeat (2) @(negedge i_clock);
    `CHK({o_mac_rxd, o_mac_rxer, o_mac_col}, 6'h00);
    i_if_disable = 1'b0;
    i_line_carrier = 1'b0;
  endtask
  // Main sequence: MII first, then RMII after a second reset
  initial begin
    i_clock = 1'b0;
    i_nrst = 1'b0;
    i_mode_strap = 1'b0;
    i_if_disable = 1'b0;
    i_speed_100 = 1'b1;
    i_full_duplex = 1'b0;
    i_line_carrier = 1'b0;
    i_line_rx_valid = 1'b0;
    i_line_rx_nib = 4'h0;
    i_line_rx_err = 1'b0;
    i_line_rx_sfd = 1'b0;
    rmon = 1'b0;
    saw_full = 1'b0;
    saw_err = 1'b0;
    @(negedge i_clock);
    t_reset(1'b0);
    t_mii_tx();
    t_mii_rx(1'b1);
    t_mii_rx(1'b0);
    t_col();
    t_reset(1'b1);
    t_rmii_tx(1'b1);
    t_rmii_tx(1'b0);
    t_rmii_rx();
    t_disable();
    stop_test();
  end
  // Watchdog well past the expected run
  initial begin
    #2_000_000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
